// >>> rtl/epf_cfg.svh
// Behaviour
// - Watt and var sign bits written during a code pass are held in an eight-entry queue and released at the programmed spacing.
// - The queue is emptied at the start of every frame and unsent entries are dropped.
// - The spacing register sets both the delay from frame start to the first update and the gap between later updates.
// - One count of the spacing register equals four filter clock cycles.
// - A spacing of zero bypasses the queue and the outputs follow each new value two clock edges after it is written.
// - With the queue active, an active pulse is cut after (2 * width limit + 1) update intervals.
// - A width limit of 255 or a spacing of zero disables the cut, leaving the pulses at their natural duty.
// - Pulses are active low after reset; setting the polarity bit makes every pulse output active high.
// - Watt and var pulses drive their own pins and may also be routed to the optical pin by a two-bit select.
// - Frame length in filter clocks follows the fast or slow formula from filter length, converter and multiplexer dividers.
// - Exactly one sample of each selected channel is requested in every frame.
// - The number of frames in one accumulation equals the 13-bit sample count split over two bytes.
// - At the end of each accumulation the accumulation-done flag is raised.
// - At the end of each frame the frame-done flag is raised.
// - Both done flags are cleared when the compute engine halts at the end of its pass.
`ifndef EPF_CFG_SVH
`define EPF_CFG_SVH

// register offsets in the configuration space
`define EPF_ADDR_ACC_HI     16'h2107
`define EPF_ADDR_ACC_LO     16'h2108
`define EPF_ADDR_WIDTH_LIM  16'h210A
`define EPF_ADDR_SPACING    16'h210B
`define EPF_ADDR_POLARITY   16'h210C
`define EPF_ADDR_OPT_SEL    16'h2456

// reset values
`define EPF_RST_WIDTH_LIM   8'hFF
`define EPF_RST_SPACING     8'h00
`define EPF_RST_ACC_COUNT   13'h0000

// field layout
`define EPF_ACC_HI_BITS     4:0
`define EPF_OPT_SEL_BITS    3:2
`define EPF_POL_BIT         0

// timing constants
`define EPF_WIDTH_NO_LIMIT  8'hFF
`define EPF_FAST_ADD        16'h0001
`define EPF_FAST_MULT       16'h0096
`define EPF_SLOW_ADD        16'h0003
`define EPF_SLOW_SCALE      16'h0003
`define EPF_SLOW_MULT       16'h0030
`define EPF_FRAME_MIN       16'h0002
`define EPF_FIFO_DEPTH      8
`define EPF_FIFO_AW         3

`endif

// >>> rtl/epf_pkg.sv
package epf_pkg;
   // pulse scheduling mode
   typedef enum logic [0:0] {
      EPF_BYPASS = 1'b0,
      EPF_PACED  = 1'b1
   } epf_mode_t;

   // optical transmitter source select
   typedef enum logic [1:0] {
      EPF_OPT_OFF  = 2'b00,
      EPF_OPT_WATT = 2'b01,
      EPF_OPT_VAR  = 2'b10,
      EPF_OPT_BOTH = 2'b11
   } epf_opt_t;

   // bit 0 watt sign, bit 1 var sign
   typedef logic [1:0] epf_pair_t;
endpackage

// >>> rtl/epf_sign_fifo.sv
`timescale 1ns/1ps
`include "epf_cfg.svh"
module epf_sign_fifo
   import epf_pkg::*;
(
   // clock and reset
   input  wire logic      clk_sys,
   input  wire logic      rst_b,
   // control
   input  wire logic      clear,
   input  wire logic      push,
   input  wire epf_pair_t pushData,
   input  wire logic      pop,
   // status and data
   output epf_pair_t      popData,
   output logic           empty,
   output logic           full
);
   epf_pair_t               mem [`EPF_FIFO_DEPTH];
   logic [`EPF_FIFO_AW:0]   wrPtr;
   logic [`EPF_FIFO_AW:0]   rdPtr;
   logic [`EPF_FIFO_AW:0]   next_wrPtr;
   logic [`EPF_FIFO_AW:0]   next_rdPtr;
   logic                    doPush;

   assign empty   = (wrPtr == rdPtr);
   assign full    = (wrPtr[`EPF_FIFO_AW] != rdPtr[`EPF_FIFO_AW]) &&
                    (wrPtr[`EPF_FIFO_AW-1:0] == rdPtr[`EPF_FIFO_AW-1:0]);
   assign popData = mem[rdPtr[`EPF_FIFO_AW-1:0]];

   // a clear still lets a same-cycle push land in entry zero
   always_comb begin
      doPush     = push && (clear || !full);
      next_rdPtr = rdPtr;
      next_wrPtr = wrPtr;
      if (clear) begin
         next_rdPtr = '0;
         next_wrPtr = doPush ? (`EPF_FIFO_AW+1)'(1) : '0;
      end else begin
         if (pop && !empty) begin
            next_rdPtr = rdPtr + (`EPF_FIFO_AW+1)'(1);
         end
         if (doPush) begin
            next_wrPtr = wrPtr + (`EPF_FIFO_AW+1)'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
      end
   end

   // storage has no reset; pointers define what is valid
   always_ff @(posedge clk_sys) begin
      if (doPush) begin
         mem[clear ? `EPF_FIFO_AW'(0) : wrPtr[`EPF_FIFO_AW-1:0]] <= pushData;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   chk_fifo_clear_empty: assert property (
      clear && !push |=> empty)
      else $error("queue not empty after clear");
endmodule // epf_sign_fifo

// >>> rtl/epf_pulse_gen.sv
`timescale 1ns/1ps
`include "epf_cfg.svh"
module epf_pulse_gen
   import epf_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // configuration space port
   input  wire logic [15:0] ioAddr,
   input  wire logic        ioWrEn,
   input  wire logic [7:0]  ioWrData,
   output logic [7:0]       ioRdData,
   // frame timing configuration
   input  wire logic [1:0]  filterLengthSel,
   input  wire logic        adcDiv,
   input  wire logic [3:0]  muxDiv,
   input  wire logic        pllFast,
   // compute engine side
   input  wire logic        cePulseWr,
   input  wire logic        ceWattSign,
   input  wire logic        ceVarSign,
   input  wire logic        ceHalt,
   // frame and sample strobes
   output logic             frameStart,
   output logic             sampleReq,
   // done flags
   output logic             frameDoneIrq,
   output logic             accumDoneIrq,
   // pulse pins
   output logic             wattPulseOut,
   output logic             varPulseOut,
   output logic             opticalTxPin
);
   // configuration registers
   logic [7:0]  pulseWidthLimit;
   logic [7:0]  pulseUpdateSpacing;
   logic [12:0] accumSampleCount;
   logic        pulsePolarityFlip;
   epf_opt_t    opticalTxSelect;

   // decoding shared by the write and read paths
   function automatic logic addrIs(input logic [15:0] a, input logic [15:0] target);
      return a == target;
   endfunction

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pulseWidthLimit    <= `EPF_RST_WIDTH_LIM;
         pulseUpdateSpacing <= `EPF_RST_SPACING;
         accumSampleCount   <= `EPF_RST_ACC_COUNT;
         pulsePolarityFlip  <= 1'b0;
         opticalTxSelect    <= EPF_OPT_OFF;
      end else if (ioWrEn) begin
         if (addrIs(ioAddr, `EPF_ADDR_WIDTH_LIM)) pulseWidthLimit    <= ioWrData;
         if (addrIs(ioAddr, `EPF_ADDR_SPACING))   pulseUpdateSpacing <= ioWrData;
         if (addrIs(ioAddr, `EPF_ADDR_ACC_HI))
            accumSampleCount[12:8] <= ioWrData[`EPF_ACC_HI_BITS];
         if (addrIs(ioAddr, `EPF_ADDR_ACC_LO))    accumSampleCount[7:0] <= ioWrData;
         if (addrIs(ioAddr, `EPF_ADDR_POLARITY))  pulsePolarityFlip <= ioWrData[`EPF_POL_BIT];
         if (addrIs(ioAddr, `EPF_ADDR_OPT_SEL))
            opticalTxSelect <= epf_opt_t'(ioWrData[`EPF_OPT_SEL_BITS]);
      end
   end

   // read data registered; unmapped and reserved bits read zero
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ioRdData <= 8'h00;
      end else begin
         ioRdData <= 8'h00;
         if (addrIs(ioAddr, `EPF_ADDR_WIDTH_LIM)) ioRdData <= pulseWidthLimit;
         if (addrIs(ioAddr, `EPF_ADDR_SPACING))   ioRdData <= pulseUpdateSpacing;
         if (addrIs(ioAddr, `EPF_ADDR_ACC_HI))    ioRdData <= {3'h0, accumSampleCount[12:8]};
         if (addrIs(ioAddr, `EPF_ADDR_ACC_LO))    ioRdData <= accumSampleCount[7:0];
         if (addrIs(ioAddr, `EPF_ADDR_POLARITY))  ioRdData <= {7'h00, pulsePolarityFlip};
         if (addrIs(ioAddr, `EPF_ADDR_OPT_SEL))   ioRdData <= {4'h0, opticalTxSelect, 2'h0};
      end
   end

   // frame length; the divide is by one or two only
   logic [15:0] muxProd;
   logic [15:0] frameLenRaw;
   logic [15:0] frameLen;
   always_comb begin
      muxProd = (16'(filterLengthSel) + 16'h0001) * (16'(adcDiv) + 16'h0001) * 16'(muxDiv);
      if (pllFast) begin
         frameLenRaw = ((`EPF_FAST_ADD + muxProd) * `EPF_FAST_MULT) /
                       (16'(adcDiv) + 16'h0001);
      end else begin
         frameLenRaw = ((`EPF_SLOW_ADD + `EPF_SLOW_SCALE * muxProd) * `EPF_SLOW_MULT) /
                       (16'(adcDiv) + 16'h0001);
      end
      frameLen = (frameLenRaw < `EPF_FRAME_MIN) ? `EPF_FRAME_MIN : frameLenRaw;
   end

   // frame and accumulation counters, done flags
   logic [15:0] frameCnt;
   logic [15:0] next_frameCnt;
   logic [12:0] accumCnt;
   logic [12:0] next_accumCnt;
   logic        next_frameDoneIrq;
   logic        next_accumDoneIrq;
   logic        frameEnd;
   logic        accumEnd;
   assign frameStart = (frameCnt == 16'h0000);
   assign sampleReq  = frameStart;
   always_comb begin
      frameEnd      = (frameCnt >= frameLen - 16'h0001);
      next_frameCnt = frameEnd ? 16'h0000 : frameCnt + 16'h0001;
      accumEnd      = frameEnd && (accumSampleCount != 13'h0000) &&
                      (accumCnt + 13'h0001 >= accumSampleCount);
      next_accumCnt = accumEnd ? 13'h0000 : (frameEnd ? accumCnt + 13'h0001 : accumCnt);
      // set wins over the halt clear so a done edge is never lost
      next_frameDoneIrq = frameEnd || (frameDoneIrq && !ceHalt);
      next_accumDoneIrq = accumEnd || (accumDoneIrq && !ceHalt);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         frameCnt     <= 16'h0000;
         accumCnt     <= 13'h0000;
         frameDoneIrq <= 1'b0;
         accumDoneIrq <= 1'b0;
      end else begin
         frameCnt     <= next_frameCnt;
         accumCnt     <= next_accumCnt;
         frameDoneIrq <= next_frameDoneIrq;
         accumDoneIrq <= next_accumDoneIrq;
      end
   end

   // update slot scheduler
   epf_mode_t   mode;
   logic [9:0]  slotCnt;
   logic [9:0]  next_slotCnt;
   logic [9:0]  slotLen;
   logic        slotPulse;
   epf_pair_t   rawSign;
   epf_pair_t   next_rawSign;
   epf_pair_t   fifoData;
   logic        fifoEmpty;
   logic        fifoPop;
   always_comb begin
      mode      = (pulseUpdateSpacing == 8'h00) ? EPF_BYPASS : EPF_PACED;
      slotLen   = {pulseUpdateSpacing, 2'b00};
      slotPulse = 1'b0;
      fifoPop   = 1'b0;
      next_slotCnt = slotCnt + 10'h001;
      next_rawSign = rawSign;
      case (mode)
         EPF_BYPASS: begin
            next_slotCnt = 10'h000;
            if (cePulseWr) next_rawSign = {ceVarSign, ceWattSign};
         end
         EPF_PACED: begin
            // first slot lands one spacing after frame start
            slotPulse = !frameStart && (slotCnt == slotLen - 10'h001);
            if (frameStart || slotPulse) next_slotCnt = 10'h000;
            if (slotPulse && !fifoEmpty) begin
               fifoPop      = 1'b1;
               next_rawSign = fifoData;
            end
         end
         default: next_slotCnt = 10'h000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         slotCnt <= 10'h000;
         rawSign <= 2'b00;
      end else begin
         slotCnt <= next_slotCnt;
         rawSign <= next_rawSign;
      end
   end

   // signs queued only while paced; frame start flushes stale ones
   epf_sign_fifo u_fifo (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .clear    (frameStart),
      .push     (cePulseWr && (mode == EPF_PACED)),
      .pushData ({ceVarSign, ceWattSign}),
      .pop      (fifoPop),
      .popData  (fifoData),
      .empty    (fifoEmpty),
      .full     ()
   );

   // width limit per pulse channel
   logic [18:0] limitCycles;
   logic        limited;
   logic [1:0]  actv;
   logic [1:0]  pinLvl;
   logic [18:0] widthCnt [2];
   assign limitCycles = {pulseWidthLimit, 1'b1} * slotLen;
   assign limited     = (mode == EPF_PACED) && (pulseWidthLimit != `EPF_WIDTH_NO_LIMIT);

   for (genvar ch = 0; ch < 2; ch++) begin : g_width
      logic [18:0] next_widthCnt;
      always_comb begin
         next_widthCnt = rawSign[ch] ? widthCnt[ch] : 19'h0_0000;
         if (rawSign[ch] && widthCnt[ch] < limitCycles) next_widthCnt = widthCnt[ch] + 19'h0_0001;
         // the cut holds until the sign itself drops
         actv[ch] = rawSign[ch] && !(limited && widthCnt[ch] >= limitCycles);
         pinLvl[ch] = pulsePolarityFlip ? actv[ch] : !actv[ch];
      end
      always_ff @(posedge clk_sys) begin
         if (!rst_b) widthCnt[ch] <= 19'h0_0000;
         else widthCnt[ch] <= next_widthCnt;
      end
   end

   // pins registered; optical idles at the inactive level
   logic nextOpt;
   always_comb begin
      case (opticalTxSelect)
         EPF_OPT_WATT: nextOpt = pinLvl[0];
         EPF_OPT_VAR:  nextOpt = pinLvl[1];
         EPF_OPT_BOTH: nextOpt = pulsePolarityFlip ? |actv : !(|actv);
         default:      nextOpt = !pulsePolarityFlip;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wattPulseOut <= 1'b1;
         varPulseOut  <= 1'b1;
         opticalTxPin <= 1'b1;
      end else begin
         wattPulseOut <= pinLvl[0];
         varPulseOut  <= pinLvl[1];
         opticalTxPin <= nextOpt;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_frameKick;
      frameStart && (pulseUpdateSpacing == 8'h01) && (frameLen > 16'h0008) && !ioWrEn;
   endsequence

   chk_first_slot: assert property (
      s_frameKick |-> !slotPulse [*4] ##1 slotPulse)
      else $error("first update slot misplaced");
   chk_bypass_follow: assert property (
      (mode == EPF_BYPASS) && cePulseWr |=> rawSign[0] == $past(ceWattSign))
      else $error("bypass did not follow sign");
   chk_idle_level: assert property (
      !rawSign[0] |=> wattPulseOut == !$past(pulsePolarityFlip))
      else $error("idle level wrong for polarity");
   chk_width_cap: assert property (
      limited && (widthCnt[0] >= limitCycles) |=> wattPulseOut == !$past(pulsePolarityFlip))
      else $error("pulse exceeded width limit");
   chk_no_limit: assert property (
      !limited && rawSign[0] |=> wattPulseOut == $past(pulsePolarityFlip))
      else $error("pulse cut without limit");
   chk_frame_done: assert property (
      frameEnd |=> frameDoneIrq && frameStart)
      else $error("frame done not raised");
   chk_accum_done: assert property (
      accumEnd |=> accumDoneIrq)
      else $error("accumulation done not raised");
   chk_halt_clear: assert property (
      ceHalt && !frameEnd && !accumEnd |=> !frameDoneIrq && !accumDoneIrq)
      else $error("halt did not clear flags");
   chk_slot_pop: assert property (
      slotPulse && !fifoEmpty |=> rawSign == $past(fifoData))
      else $error("slot did not load queued sign");
endmodule // epf_pulse_gen

// >>> verification/epf_ce_model.sv
`timescale 1ns/1ps
module epf_ce_model (
   // clock
   input  wire logic clk_sys,
   // sign pairs toward the pulse block
   output logic      cePulseWr,
   output logic      ceWattSign,
   output logic      ceVarSign
);
   // quiet start, no write pending
   initial begin
      cePulseWr  = 1'b0;
      ceWattSign = 1'b0;
      ceVarSign  = 1'b0;
   end

   // one pair per edge; strobe stays up when more follow so it never toggles in one step
   task automatic send(input logic [1:0] pair, input bit more);
      cePulseWr  = 1'b1;
      ceWattSign = pair[0];
      ceVarSign  = pair[1];
      @(posedge clk_sys);
      #1;
      if (!more) begin
         cePulseWr  = 1'b0;
         ceWattSign = ~pair[0]; // stale data inverted, never mistaken for valid
         ceVarSign  = ~pair[1];
      end
   endtask
endmodule // epf_ce_model

// >>> verification/epf_pulse_gen_bench.sv
`timescale 1ns/1ps
`include "epf_cfg.svh"
module epf_pulse_gen_bench
   import epf_pkg::*;
;
   logic        clk_sys, rst_b, ioWrEn, adcDiv, pllFast, ceHalt, pol;
   logic [15:0] ioAddr;
   logic [7:0]  ioWrData, ioRdData;
   logic [1:0]  filterLengthSel;
   logic [3:0]  muxDiv;
   logic        cePulseWr, ceWattSign, ceVarSign, frameStart, sampleReq;
   logic        frameDoneIrq, accumDoneIrq, wattPulseOut, varPulseOut, opticalTxPin;
   int          badCount, samplesChecked, cyc, n, i, k;
   epf_pair_t   q[$];
   epf_pair_t   last, p;

   epf_pulse_gen DUT (.clk_sys, .rst_b, .ioAddr, .ioWrEn, .ioWrData, .ioRdData,
      .filterLengthSel, .adcDiv, .muxDiv, .pllFast, .cePulseWr, .ceWattSign,
      .ceVarSign, .ceHalt, .frameStart, .sampleReq, .frameDoneIrq, .accumDoneIrq,
      .wattPulseOut, .varPulseOut, .opticalTxPin);
   epf_ce_model CE (.clk_sys, .cePulseWr, .ceWattSign, .ceVarSign);

   // 50 MHz filter clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         badCount++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // all stimulus moves 1 ns after the edge
   task automatic tick();
      @(posedge clk_sys);
      #1;
      cyc++;
   endtask

   task automatic runTo(input int t);
      while (cyc < t) tick();
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      ioAddr   = a;
      ioWrEn   = 1'b1;
      ioWrData = d;
      tick();
      ioWrEn = 1'b0;
      tick();
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
      ioAddr = a;
      tick();
      check(what, 16'(ioRdData), 16'(exp));
   endtask

   task automatic halt();
      ceHalt = 1'b1;
      tick();
      ceHalt = 1'b0;
   endtask

   // partner write; each pair costs one edge, so the cycle count follows it
   task automatic ceSend(input epf_pair_t pair, input bit more);
      CE.send(pair, more);
      cyc++;
   endtask

   // bounded wait; leaves cyc at 0 in the frame start cycle
   task automatic waitFrame(output int len);
      for (len = 1; len < 1000; len++) begin
         tick();
         if (frameStart === 1'b1) begin
            cyc = 0;
            return;
         end
      end
      badCount++;
      $display("MISMATCH frame start expected 1 seen 0");
      wrapUp();
   endtask

   function automatic logic pinOf(input logic act);
      return pol ? act : ~act;
   endfunction

   function automatic int frameExp(input int f, input int a, input int m, input bit fast);
      int len;
      len = fast ? (1 + (f + 1) * (a + 1) * m) * 150 / (a + 1)
                 : (3 + 3 * (f + 1) * (a + 1) * m) * 48 / (a + 1);
      return (len < 2) ? 2 : len;
   endfunction

   // pins against the queue model, watt in bit 0
   task automatic pins(input epf_pair_t s, input string what);
      check(what, 16'({wattPulseOut, varPulseOut}), 16'({pinOf(s[0]), pinOf(s[1])}));
   endtask

   // main sequence
   initial begin
      rst_b = 1'b0; ioAddr = '0; ioWrEn = 1'b0; ioWrData = '0; ceHalt = 1'b0;
      filterLengthSel = '0; adcDiv = 1'b0; muxDiv = '0; pllFast = 1'b1; pol = 1'b0;
      badCount = 0; samplesChecked = 0; cyc = 0;
      void'($urandom(82619));
      repeat (3) tick();
      check("reset pins", 16'({wattPulseOut, varPulseOut, opticalTxPin}), 16'h0007);
      rst_b = 1'b1;
      // register map, reset values and reserved bits
      rd(`EPF_ADDR_WIDTH_LIM, 8'hFF, "width limit");
      rd(`EPF_ADDR_SPACING, 8'h00, "spacing");
      rd(`EPF_ADDR_POLARITY, 8'h00, "polarity");
      wr(16'h2000, 8'hAA);
      rd(16'h2000, 8'h00, "unmapped");
      p = 2'($urandom);
      ioWrData = 8'($urandom);
      wr(`EPF_ADDR_SPACING, ioWrData);
      rd(`EPF_ADDR_SPACING, ioWrData, "spacing rw");
      wr(`EPF_ADDR_ACC_HI, 8'hFF);
      rd(`EPF_ADDR_ACC_HI, 8'h1F, "count hi");
      wr(`EPF_ADDR_OPT_SEL, 8'hFF);
      rd(`EPF_ADDR_OPT_SEL, 8'h0C, "optical sel");
      wr(`EPF_ADDR_ACC_HI, 8'h00);
      wr(`EPF_ADDR_SPACING, 8'h00);
      // frame length over a table of timing settings
      for (i = 0; i < 4; i++) begin
         {pllFast, adcDiv, muxDiv} = (i == 0) ? 6'h20 : (i == 1) ? 6'h00 : (i == 2) ? 6'h10 : 6'h21;
         filterLengthSel = 2'($urandom);
         waitFrame(n);
         waitFrame(n);
         waitFrame(n);
         check("frame len", 16'(n), 16'(frameExp(filterLengthSel, adcDiv, muxDiv, pllFast)));
         check("sample req", 16'(sampleReq), 16'h0001);
         check("frame done", 16'(frameDoneIrq), 16'h0001);
         halt();
         check("frame done clr", 16'(frameDoneIrq), 16'h0000);
      end
      {pllFast, adcDiv, muxDiv} = 6'h20;
      // accumulation of two frames
      wr(`EPF_ADDR_ACC_LO, 8'h02);
      for (i = 0; i < 4 && accumDoneIrq !== 1'b1; i++) waitFrame(n);
      halt();
      check("accum clr", 16'(accumDoneIrq), 16'h0000);
      for (k = 1; k < 5; k++) begin
         waitFrame(n);
         if (accumDoneIrq === 1'b1) break;
      end
      check("accum frames", 16'(k), 16'h0002);
      // bypass: each write reaches the pins, both polarities, every optical source
      for (i = 0; i < 8; i++) begin
         pol = i[2];
         wr(`EPF_ADDR_POLARITY, 8'(pol));
         wr(`EPF_ADDR_OPT_SEL, 8'(i[1:0]) << 2);
         p = 2'($urandom);
         CE.send(p, 1'b0);
         tick();
         tick();
         pins(p, "bypass pins");
         check("optical", 16'(opticalTxPin), 16'(pinOf(i[1:0] == 0 ? 1'b0 : i[1:0] == 1 ? p[0] :
            i[1:0] == 2 ? p[1] : |p)));
      end
      last = p;
      pol = 1'b0;
      wr(`EPF_ADDR_POLARITY, 8'h00);
      // paced: three pairs at frame start leave one per slot, then the level holds
      wr(`EPF_ADDR_SPACING, 8'h02);
      waitFrame(n);
      for (i = 0; i < 3; i++) begin
         p = 2'($urandom);
         q.push_back(p);
         ceSend(p, i < 2);
      end
      for (k = 1; k < 5; k++) begin
         runTo(8 * k + 3);
         if (q.size() > 0) last = q.pop_front();
         pins(last, "paced pins");
      end
      // late entry dropped by the next frame start
      wr(`EPF_ADDR_SPACING, 8'd30);
      waitFrame(n);
      ceSend(2'b00, 1'b1);
      ceSend(2'b11, 1'b0);
      runTo(123);
      pins(2'b00, "first slot");
      waitFrame(n);
      runTo(123);
      pins(2'b00, "after clear");
      // width cut after (2L+1) intervals
      wr(`EPF_ADDR_SPACING, 8'h01);
      for (i = 0; i < 2; i++) begin
         wr(`EPF_ADDR_WIDTH_LIM, 8'(i));
         waitFrame(n);
         ceSend(2'b00, 1'b1);
         ceSend(2'b11, 1'b0);
         // second slot at cycle 8 shows on the pin at 10, cut after (2L+1)*4 cycles
         runTo(9 + (2 * i + 1) * 4);
         pins(2'b11, "pulse on");
         runTo(10 + (2 * i + 1) * 4);
         pins(2'b00, "pulse cut");
      end
      // queue depth: nine pairs into eight entries, the ninth is dropped
      wr(`EPF_ADDR_WIDTH_LIM, 8'hFF);
      wr(`EPF_ADDR_SPACING, 8'h03);
      waitFrame(n);
      q.delete();
      for (i = 0; i < 9; i++) begin
         p = (i == 8) ? ~q[7] : 2'($urandom);
         if (q.size() < `EPF_FIFO_DEPTH) q.push_back(p);
         ceSend(p, i < 8);
      end
      for (k = 1; k < 10; k++) begin
         runTo(12 * k + 3);
         if (q.size() > 0) last = q.pop_front();
         pins(last, "queue depth");
      end
      wrapUp();
   end
endmodule // epf_pulse_gen_bench
